// ===== cmb_pkg.sv
// Purpose: Shared constants and types for the move, branch and system instruction unit.
// Assumes: 16-bit words, 8-bit code segments, 10-bit data page pointers.
// Notes: Operation codes are internal class codes handed over by the decoder.
package cmb_pkg;
  // Instruction classes as presented by the decoder.
  localparam logic [4:0] OP_MOVE = 5'h00;
  localparam logic [4:0] OP_MOVE_SX = 5'h01;
  localparam logic [4:0] OP_MOVE_ZX = 5'h02;
  localparam logic [4:0] OP_JUMP_ABS = 5'h03;
  localparam logic [4:0] OP_JUMP_IND = 5'h04;
  localparam logic [4:0] OP_JUMP_REL = 5'h05;
  localparam logic [4:0] OP_JUMP_SEG = 5'h06;
  localparam logic [4:0] OP_BRANCH_SET = 5'h07;
  localparam logic [4:0] OP_BRANCH_CLR = 5'h08;
  localparam logic [4:0] OP_BRANCH_CLEAR_BIT = 5'h09;
  localparam logic [4:0] OP_BRANCH_SET_BIT = 5'h0a;
  localparam logic [4:0] OP_CALL_ABS = 5'h0b;
  localparam logic [4:0] OP_CALL_IND = 5'h0c;
  localparam logic [4:0] OP_CALL_REL = 5'h0d;
  localparam logic [4:0] OP_CALL_SEG = 5'h0e;
  localparam logic [4:0] OP_PUSH_CALL = 5'h0f;
  localparam logic [4:0] OP_TRAP = 5'h10;
  localparam logic [4:0] OP_PUSH = 5'h11;
  localparam logic [4:0] OP_POP = 5'h12;
  localparam logic [4:0] OP_CTX_SWITCH = 5'h13;
  localparam logic [4:0] OP_RETURN_NEAR = 5'h14;
  localparam logic [4:0] OP_RETURN_FAR = 5'h15;
  localparam logic [4:0] OP_RETURN_RESTORE = 5'h16;
  localparam logic [4:0] OP_RETURN_INT = 5'h17;
  localparam logic [4:0] OP_IDLE = 5'h18;
  localparam logic [4:0] OP_POWER_DOWN = 5'h19;
  localparam logic [4:0] OP_END_INIT = 5'h1a;
  localparam logic [4:0] OP_EXT_PAGE = 5'h1b;
  localparam logic [4:0] OP_EXT_SEG = 5'h1c;
  localparam logic [4:0] OP_NOP = 5'h1d;

  // Instruction lengths in bytes.
  localparam logic [2:0] LEN_SHORT = 3'h2;
  localparam logic [2:0] LEN_LONG = 3'h4;

  // Stack geometry and reset values.
  localparam int STACK_DEPTH = 16;
  localparam logic [3:0] SP_RESET = 4'h0;
  localparam logic [15:0] PC_RESET = 16'h0000;
  localparam logic [7:0] SEG_RESET = 8'h00;

  // Trap numbers land on vectors four bytes apart in segment zero.
  localparam logic [6:0] ILLEGAL_TRAP_NUM = 7'h04;
  localparam logic [7:0] TRAP_SEG = 8'h00;

  // Short register addresses are word indices into these bases.
  localparam logic [23:0] SFR_BASE = 24'h00fe00;
  localparam logic [23:0] ESFR_BASE = 24'h00f000;

  // States of the sequencer, one-hot.
  typedef enum logic [3:0] {
    S_EXEC = 4'h1,
    S_PUSH2 = 4'h2,
    S_POP2 = 4'h4,
    S_HALT = 4'h8
  } cmb_state_e;
endpackage

// ===== cmb_exec_unit.sv
// Purpose: Executes moves, branches, inter_segment_call, returns, traps, stack, system and prefix ops.
// Assumes: The decoder supplies operands, condition result and bit value with the request.
// Notes: Holds the program counter, code segment, system stack and sequence prefix state.
`timescale 1ns/100ps
module cmb_exec_unit
  import cmb_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // Instruction request
  input wire logic instValid,
  input wire logic [4:0] instOp,
  input wire logic [2:0] instLen,
  input wire logic instByte,
  input wire logic instCond,
  input wire logic instBit,
  input wire logic instExtReg,
  input wire logic [15:0] srcData,
  input wire logic [15:0] regData,
  input wire logic [15:0] tgtAddr,
  input wire logic [7:0] tgtSeg,
  input wire logic [6:0] trapNum,
  input wire logic [1:0] prefixSpan,
  input wire logic [9:0] prefixValue,
  output logic instReady,
  // Data addressing
  input wire logic sfrShortMode,
  input wire logic [7:0] sfrShortAddr,
  input wire logic [15:0] dataOffset,
  input wire logic [9:0] dppPage,
  output logic [23:0] dataAddrQ,
  // Results
  output logic [15:0] pcQ,
  output logic [7:0] segQ,
  output logic wbValidQ,
  output logic wbByteQ,
  output logic [15:0] wbDataQ,
  output logic bitWrValidQ,
  output logic bitWrValueQ,
  output logic illegalTrapQ,
  // System control
  input wire logic wakeReq,
  input wire logic nmiPinN,
  output logic idleQ,
  output logic powerDownQ,
  output logic rstOutPinNQ,
  output logic extActiveQ
);

  // ******************************************************************
  // Declarations
  // ******************************************************************
  cmb_state_e stateQ, stateD;
  logic [15:0] stackMem [STACK_DEPTH];
  logic [3:0] spQ, spD;
  logic [15:0] pcD, pendWordQ, pendWordD, retPc, popWord;
  logic [7:0] segD;
  logic popToSegQ, popToSegD, pushEn, legal, accept;
  logic [15:0] pushData, wbDataD;
  logic wbValidD, wbByteD, bitWrValidD, bitWrValueD, illegalD;
  logic nmiMetaQ, nmiSyncQ;
  logic [2:0] extCountQ;
  logic extSegQ, extRegQ;
  logic [9:0] extValueQ;

  // Accepted lengths per class; unknown classes have none.
  function automatic logic lenOk(input logic [4:0] op, input logic [2:0] len);
    unique case (op)
      OP_MOVE, OP_MOVE_SX, OP_MOVE_ZX, OP_EXT_PAGE, OP_EXT_SEG:
        lenOk = (len == LEN_SHORT) || (len == LEN_LONG);
      OP_TRAP, OP_PUSH, OP_POP, OP_RETURN_NEAR, OP_RETURN_FAR, OP_RETURN_RESTORE,
      OP_RETURN_INT, OP_NOP:
        lenOk = (len == LEN_SHORT);
      OP_JUMP_ABS, OP_JUMP_IND, OP_JUMP_REL, OP_JUMP_SEG, OP_BRANCH_SET, OP_BRANCH_CLR,
      OP_BRANCH_CLEAR_BIT, OP_BRANCH_SET_BIT, OP_CALL_ABS, OP_CALL_IND, OP_CALL_REL,
      OP_CALL_SEG, OP_PUSH_CALL, OP_CTX_SWITCH, OP_IDLE, OP_POWER_DOWN, OP_END_INIT:
        lenOk = (len == LEN_LONG);
      default:
        lenOk = 1'b0;
    endcase
  endfunction

  assign instReady = (stateQ == S_EXEC);
  assign accept = instValid && instReady;
  assign legal = lenOk(instOp, instLen);
  assign retPc = pcQ + {13'h0000, instLen};
  assign popWord = stackMem[spQ - 4'h1];

  // ******************************************************************
  // Sequencer
  // ******************************************************************
  always_comb begin
    stateD = stateQ;
    pcD = pcQ;
    segD = segQ;
    spD = spQ;
    pendWordD = pendWordQ;
    popToSegD = popToSegQ;
    pushEn = 1'b0;
    pushData = pendWordQ;
    wbValidD = 1'b0;
    wbByteD = 1'b0;
    wbDataD = wbDataQ;
    bitWrValidD = 1'b0;
    bitWrValueD = 1'b0;
    illegalD = 1'b0;
    unique case (stateQ)
      S_EXEC: begin
        if (accept && !legal) begin
          illegalD = 1'b1;
          pushEn = 1'b1;
          pushData = {8'h00, segQ};
          pendWordD = pcQ;
          segD = TRAP_SEG;
          pcD = {7'h00, ILLEGAL_TRAP_NUM, 2'b00};
          stateD = S_PUSH2;
        end else if (accept) begin
          pcD = retPc;
          unique case (instOp)
            OP_MOVE: begin
              wbValidD = 1'b1;
              wbByteD = instByte;
              wbDataD = instByte ? {8'h00, srcData[7:0]} : srcData;
            end
            OP_MOVE_SX: begin
              wbValidD = 1'b1;
              wbDataD = {{8{srcData[7]}}, srcData[7:0]};
            end
            OP_MOVE_ZX: begin
              wbValidD = 1'b1;
              wbDataD = {8'h00, srcData[7:0]};
            end
            OP_JUMP_ABS: if (instCond) pcD = tgtAddr;
            OP_JUMP_IND: if (instCond) pcD = regData;
            OP_JUMP_REL: if (instCond) pcD = retPc + tgtAddr;
            OP_JUMP_SEG: begin
              segD = tgtSeg;
              pcD = tgtAddr;
            end
            OP_BRANCH_SET: if (instBit) pcD = retPc + tgtAddr;
            OP_BRANCH_CLR: if (!instBit) pcD = retPc + tgtAddr;
            OP_BRANCH_CLEAR_BIT: if (instBit) begin
              pcD = retPc + tgtAddr;
              bitWrValidD = 1'b1;
              bitWrValueD = 1'b0;
            end
            OP_BRANCH_SET_BIT: if (!instBit) begin
              pcD = retPc + tgtAddr;
              bitWrValidD = 1'b1;
              bitWrValueD = 1'b1;
            end
            OP_CALL_ABS, OP_CALL_IND, OP_CALL_REL: if (instCond) begin
              pushEn = 1'b1;
              pushData = retPc;
              pcD = (instOp == OP_CALL_ABS) ? tgtAddr :
                    (instOp == OP_CALL_IND) ? regData : retPc + tgtAddr;
            end
            OP_CALL_SEG, OP_TRAP: begin
              pushEn = 1'b1;
              pushData = {8'h00, segQ};
              pendWordD = retPc;
              segD = (instOp == OP_TRAP) ? TRAP_SEG : tgtSeg;
              pcD = (instOp == OP_TRAP) ? {7'h00, trapNum, 2'b00} : tgtAddr;
              stateD = S_PUSH2;
            end
            OP_PUSH_CALL: begin
              pushEn = 1'b1;
              pushData = regData;
              pendWordD = retPc;
              pcD = tgtAddr;
              stateD = S_PUSH2;
            end
            OP_PUSH: begin
              pushEn = 1'b1;
              pushData = regData;
            end
            OP_POP: begin
              spD = spQ - 4'h1;
              wbValidD = 1'b1;
              wbDataD = popWord;
            end
            OP_CTX_SWITCH: begin
              pushEn = 1'b1;
              pushData = regData;
              wbValidD = 1'b1;
              wbDataD = srcData;
            end
            OP_RETURN_NEAR, OP_RETURN_FAR, OP_RETURN_RESTORE, OP_RETURN_INT: begin
              spD = spQ - 4'h1;
              pcD = popWord;
              popToSegD = (instOp != OP_RETURN_RESTORE);
              if (instOp != OP_RETURN_NEAR) stateD = S_POP2;
            end
            OP_IDLE: stateD = S_HALT;
            OP_POWER_DOWN: if (!nmiSyncQ) stateD = S_HALT;
            default: ;
          endcase
        end
      end
      S_PUSH2: begin
        pushEn = 1'b1;
        stateD = S_EXEC;
      end
      S_POP2: begin
        spD = spQ - 4'h1;
        if (popToSegQ) begin
          segD = popWord[7:0];
        end else begin
          wbValidD = 1'b1;
          wbDataD = popWord;
        end
        stateD = S_EXEC;
      end
      S_HALT: if (idleQ && wakeReq) stateD = S_EXEC;
      default: stateD = S_EXEC;
    endcase
    if (pushEn) spD = spQ + 4'h1;
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      stateQ <= S_EXEC;
      pcQ <= PC_RESET;
      segQ <= SEG_RESET;
      spQ <= SP_RESET;
      pendWordQ <= 16'h0000;
      popToSegQ <= 1'b0;
      wbValidQ <= 1'b0;
      wbByteQ <= 1'b0;
      wbDataQ <= 16'h0000;
      bitWrValidQ <= 1'b0;
      bitWrValueQ <= 1'b0;
      illegalTrapQ <= 1'b0;
    end else begin
      stateQ <= stateD;
      pcQ <= pcD;
      segQ <= segD;
      spQ <= spD;
      pendWordQ <= pendWordD;
      popToSegQ <= popToSegD;
      wbValidQ <= wbValidD;
      wbByteQ <= wbByteD;
      wbDataQ <= wbDataD;
      bitWrValidQ <= bitWrValidD;
      bitWrValueQ <= bitWrValueD;
      illegalTrapQ <= illegalD;
    end
  end

  // The stack array has no reset; the pointer alone defines its content.
  always_ff @(posedge clk_sys) begin
    if (pushEn) stackMem[spQ] <= pushData;
  end

  // ******************************************************************
  // Power modes and reset output
  // ******************************************************************
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      nmiMetaQ <= 1'b1;
      nmiSyncQ <= 1'b1;
    end else begin
      nmiMetaQ <= nmiPinN;
      nmiSyncQ <= nmiMetaQ;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      idleQ <= 1'b0;
      powerDownQ <= 1'b0;
      rstOutPinNQ <= 1'b0;
    end else begin
      if (accept && legal && instOp == OP_IDLE) idleQ <= 1'b1;
      else if (idleQ && wakeReq) idleQ <= 1'b0;
      if (accept && legal && instOp == OP_POWER_DOWN && !nmiSyncQ) powerDownQ <= 1'b1;
      if (accept && legal && instOp == OP_END_INIT) rstOutPinNQ <= 1'b1;
    end
  end

  // ******************************************************************
  // Sequence prefixes and data addressing
  // ******************************************************************
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      extCountQ <= 3'h0;
      extSegQ <= 1'b0;
      extRegQ <= 1'b0;
      extValueQ <= 10'h000;
    end else if (accept && legal && (instOp == OP_EXT_PAGE || instOp == OP_EXT_SEG)) begin
      extCountQ <= {1'b0, prefixSpan} + 3'h1;
      extSegQ <= (instOp == OP_EXT_SEG);
      extRegQ <= instExtReg;
      extValueQ <= prefixValue;
    end else if (accept && extCountQ != 3'h0) begin
      extCountQ <= extCountQ - 3'h1;
    end
  end
  assign extActiveQ = (extCountQ != 3'h0);

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      dataAddrQ <= 24'h000000;
    end else if (accept) begin
      if (sfrShortMode) begin
        dataAddrQ <= ((extActiveQ && extRegQ) ? ESFR_BASE : SFR_BASE)
                     + {15'h0000, sfrShortAddr, 1'b0};
      end else if (extActiveQ && extSegQ) begin
        dataAddrQ <= {extValueQ[7:0], dataOffset};
      end else if (extActiveQ) begin
        dataAddrQ <= {extValueQ, dataOffset[13:0]};
      end else begin
        dataAddrQ <= {dppPage, dataOffset[13:0]};
      end
    end
  end

  // ******************************************************************
  // Checks
  // ******************************************************************
  sequence seqFarCall;
    accept && legal && instOp == OP_CALL_SEG;
  endsequence
  sequence seqTwoPushes;
    ##1 (stateQ == S_PUSH2) ##1 (stateQ == S_EXEC && spQ == $past(spQ, 2) + 4'h2);
  endsequence

  chk_move_zero_ext: assert property (@(posedge clk_sys) disable iff (!resetn)
    accept && legal && instOp == OP_MOVE_ZX |=> wbValidQ && wbDataQ[15:8] == 8'h00
      && wbDataQ[7:0] == $past(srcData[7:0])) else $error("zero extension wrong");
  chk_move_sign_ext: assert property (@(posedge clk_sys) disable iff (!resetn)
    accept && legal && instOp == OP_MOVE_SX |=> wbDataQ[15:8] == {8{$past(srcData[7])}})
    else $error("sign extension wrong");
  chk_jump_taken: assert property (@(posedge clk_sys) disable iff (!resetn)
    accept && legal && instOp == OP_JUMP_ABS && instCond |=> pcQ == $past(tgtAddr))
    else $error("jump not taken");
  chk_jump_skipped: assert property (@(posedge clk_sys) disable iff (!resetn)
    accept && legal && instOp == OP_JUMP_ABS && !instCond |=> pcQ == $past(retPc))
    else $error("jump taken on false condition");
  chk_clear_bit: assert property (@(posedge clk_sys) disable iff (!resetn)
    accept && legal && instOp == OP_BRANCH_CLEAR_BIT |=> bitWrValidQ == $past(instBit)
      && !bitWrValueQ) else $error("test-and-clear bit write wrong");
  chk_set_bit_hold: assert property (@(posedge clk_sys) disable iff (!resetn)
    accept && legal && instOp == OP_BRANCH_SET_BIT && instBit |=> !bitWrValidQ
      && pcQ == $past(retPc)) else $error("test-and-set acted on set bit");
  chk_far_call_push: assert property (@(posedge clk_sys) disable iff (!resetn)
    seqFarCall |-> seqTwoPushes) else $error("far call did not push twice");
  chk_power_gate: assert property (@(posedge clk_sys) disable iff (!resetn)
    accept && legal && instOp == OP_POWER_DOWN && nmiSyncQ |=> (!powerDownQ)[*2])
    else $error("power down entered with input high");
  chk_init_pin: assert property (@(posedge clk_sys) disable iff (!resetn)
    accept && legal && instOp == OP_END_INIT |=> rstOutPinNQ) else $error("reset pin unchanged");
  chk_illegal_trap: assert property (@(posedge clk_sys) disable iff (!resetn)
    accept && !legal |=> illegalTrapQ && stateQ == S_PUSH2) else $error("illegal op not trapped");

endmodule

// ===== test_cpu_move_branch_system_ops.sv
// Purpose: Self-checking bench for the move, branch and system instruction unit.
// Assumes: Registered results show in the cycle after the edge that accepts a request.
// Notes: Scenarios run in order; power down comes last because it never ends.
`timescale 1ns/100ps
module test_cpu_move_branch_system_ops;
  import cmb_pkg::*;
  // ********************
  // Stimulus and results
  // ********************
  localparam logic [15:0] ZW = 16'h0000;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic instValid = 1'b0;
  logic [4:0] instOp = OP_NOP;
  logic [2:0] instLen = LEN_SHORT;
  logic instByte = 1'b0;
  logic instCond = 1'b0;
  logic instBit = 1'b0;
  logic instExtReg = 1'b0;
  logic [15:0] srcData = 16'h0000;
  logic [15:0] regData = 16'h0000;
  logic [15:0] tgtAddr = 16'h0000;
  logic [7:0] tgtSeg = 8'h00;
  logic [6:0] trapNum = 7'h00;
  logic [1:0] prefixSpan = 2'h0;
  logic [9:0] prefixValue = 10'h000;
  logic sfrShortMode = 1'b0;
  logic [7:0] sfrShortAddr = 8'h00;
  logic [15:0] dataOffset = 16'h4321;
  logic [9:0] dppPage = 10'h2a5;
  logic wakeReq = 1'b0;
  logic nmiPinN = 1'b1;
  logic instReady, wbValidQ, wbByteQ, bitWrValidQ, bitWrValueQ, illegalTrapQ;
  logic idleQ, powerDownQ, rstOutPinNQ, extActiveQ;
  logic [23:0] dataAddrQ;
  logic [15:0] pcQ, wbDataQ;
  logic [7:0] segQ;
  logic [15:0] pcM = 16'h0000;
  int badCount = 0;
  int nChecks = 0;

  cmb_exec_unit i_dut (
    .clk_sys, .resetn, .instValid, .instOp, .instLen, .instByte, .instCond, .instBit,
    .instExtReg, .srcData, .regData, .tgtAddr, .tgtSeg, .trapNum, .prefixSpan,
    .prefixValue, .instReady, .sfrShortMode, .sfrShortAddr, .dataOffset, .dppPage,
    .dataAddrQ, .pcQ, .segQ, .wbValidQ, .wbByteQ, .wbDataQ, .bitWrValidQ, .bitWrValueQ,
    .illegalTrapQ, .wakeReq, .nmiPinN, .idleQ, .powerDownQ, .rstOutPinNQ, .extActiveQ
  );

  always #50 clk_sys = ~clk_sys;

  // ********************
  // Shared tasks
  // ********************
  task automatic results;
    $display("Checks made: %0d, mismatches: %0d", nChecks, badCount);
    if (badCount == 0 && nChecks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic compare(input logic [23:0] got, input logic [23:0] exp);
    nChecks++;
    if (got !== exp) begin
      badCount++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic tick;
    @(posedge clk_sys);
    #1;
  endtask

  // Sends one request, holds it until accepted, then checks the program counter.
  task automatic run(input logic [4:0] op, input logic [2:0] len, input logic c,
                     input logic [15:0] tgt, input logic [15:0] src, input logic [15:0] rg,
                     input logic [15:0] pcE);
    int n;
    n = 0;
    @(posedge clk_sys);
    instOp <= op;
    instLen <= len;
    instCond <= c;
    instBit <= c;
    tgtAddr <= tgt;
    srcData <= src;
    regData <= rg;
    instValid <= 1'b1;
    #1;
    // Ready is judged settled before the edge, so the request is taken exactly once.
    while (instReady !== 1'b1 && n < 20) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    if (n == 20) begin
      badCount++;
      results();
    end
    @(posedge clk_sys);
    instValid <= 1'b0;
    #1;
    compare(pcQ, pcE);
    pcM = pcE;
  endtask

  task automatic do_reset;
    @(posedge clk_sys);
    resetn <= 1'b0;
    repeat (6) @(posedge clk_sys);
    resetn <= 1'b1;
    #1;
    pcM = 16'h0000;
    compare(pcQ, PC_RESET);
    compare(segQ, SEG_RESET);
    compare(rstOutPinNQ, 1'b0);
    compare(instReady, 1'b1);
    compare(idleQ, 1'b0);
    compare(powerDownQ, 1'b0);
    compare(dataAddrQ, 24'h000000);
  endtask

  // ********************
  // Scenarios
  // ********************
  task automatic t_moves;
    logic [4:0] ops [5] = '{OP_MOVE, OP_MOVE, OP_MOVE_SX, OP_MOVE_SX, OP_MOVE_ZX};
    logic [2:0] lens [5] = '{LEN_LONG, LEN_SHORT, LEN_SHORT, LEN_LONG, LEN_LONG};
    logic [15:0] srcs [5] = '{16'h8a5c, 16'h8a5c, 16'h1280, 16'h007f, 16'hffc3};
    logic [15:0] exps [5] = '{16'h8a5c, 16'h005c, 16'hff80, 16'h007f, 16'h00c3};
    logic [4:0] byt = 5'h02;
    for (int i = 0; i < 5; i++) begin
      @(posedge clk_sys);
      instByte <= byt[i];
      run(ops[i], lens[i], 1'b0, ZW, srcs[i], ZW, pcM + 16'(lens[i]));
      compare(wbDataQ, exps[i]);
      compare(wbValidQ, 1'b1);
      if (ops[i] == OP_MOVE) begin
        compare(wbByteQ, byt[i]);
      end
      tick();
      compare(wbValidQ, 1'b0);
    end
  endtask

  task automatic t_jumps;
    run(OP_JUMP_ABS, LEN_LONG, 1'b0, 16'h0400, ZW, ZW, pcM + 16'h0004);
    run(OP_JUMP_ABS, LEN_LONG, 1'b1, 16'h0400, ZW, ZW, 16'h0400);
    run(OP_JUMP_IND, LEN_LONG, 1'b0, ZW, ZW, 16'h0600, pcM + 16'h0004);
    run(OP_JUMP_IND, LEN_LONG, 1'b1, ZW, ZW, 16'h0600, 16'h0600);
    run(OP_JUMP_REL, LEN_LONG, 1'b0, 16'h0020, ZW, ZW, pcM + 16'h0004);
    run(OP_JUMP_REL, LEN_LONG, 1'b1, 16'hfff0, ZW, ZW, pcM + 16'hfff4);
    @(posedge clk_sys);
    tgtSeg <= 8'h03;
    run(OP_JUMP_SEG, LEN_LONG, 1'b0, 16'h0800, ZW, ZW, 16'h0800);
    compare(segQ, 8'h03);
  endtask

  task automatic t_bits;
    logic [4:0] ops [8] = '{OP_BRANCH_SET, OP_BRANCH_SET, OP_BRANCH_CLR, OP_BRANCH_CLR,
      OP_BRANCH_CLEAR_BIT, OP_BRANCH_CLEAR_BIT, OP_BRANCH_SET_BIT, OP_BRANCH_SET_BIT};
    logic [7:0] bits = 8'h99;
    logic [7:0] jmp = 8'h55;
    logic [7:0] wr = 8'h50;
    for (int i = 0; i < 8; i++) begin
      run(ops[i], LEN_LONG, bits[i], 16'h0010, ZW, ZW,
          pcM + 16'h0004 + (jmp[i] ? 16'h0010 : 16'h0000));
      compare(bitWrValidQ, wr[i]);
      if (wr[i]) begin
        compare(bitWrValueQ, !bits[i]);
      end
    end
  endtask

  task automatic t_inter_segment_call;
    logic [15:0] ret;
    run(OP_CALL_REL, LEN_LONG, 1'b0, 16'h0100, ZW, ZW, pcM + 16'h0004);
    ret = pcM + 16'h0004;
    run(OP_CALL_IND, LEN_LONG, 1'b1, ZW, ZW, 16'h0a00, 16'h0a00);
    run(OP_CALL_REL, LEN_LONG, 1'b1, 16'h0100, ZW, ZW, 16'h0b04);
    run(OP_RETURN_NEAR, LEN_SHORT, 1'b0, ZW, ZW, ZW, 16'h0a04);
    run(OP_RETURN_NEAR, LEN_SHORT, 1'b0, ZW, ZW, ZW, ret);
    run(OP_CALL_ABS, LEN_LONG, 1'b1, 16'h0c00, ZW, ZW, 16'h0c00);
    @(posedge clk_sys);
    tgtSeg <= 8'h07;
    run(OP_CALL_SEG, LEN_LONG, 1'b0, 16'h0d00, ZW, ZW, 16'h0d00);
    compare(segQ, 8'h07);
    run(OP_RETURN_FAR, LEN_SHORT, 1'b0, ZW, ZW, ZW, 16'h0c04);
    tick();
    compare(segQ, 8'h03);
  endtask

  task automatic t_stack;
    logic [15:0] ret;
    run(OP_PUSH, LEN_SHORT, 1'b0, ZW, ZW, 16'h1234, pcM + 16'h0002);
    run(OP_CTX_SWITCH, LEN_LONG, 1'b0, ZW, 16'h5555, 16'habcd, pcM + 16'h0004);
    compare(wbDataQ, 16'h5555);
    run(OP_POP, LEN_SHORT, 1'b0, ZW, ZW, ZW, pcM + 16'h0002);
    compare(wbDataQ, 16'habcd);
    run(OP_POP, LEN_SHORT, 1'b0, ZW, ZW, ZW, pcM + 16'h0002);
    compare(wbDataQ, 16'h1234);
    ret = pcM + 16'h0004;
    run(OP_PUSH_CALL, LEN_LONG, 1'b0, 16'h0e00, ZW, 16'h7777, 16'h0e00);
    run(OP_RETURN_RESTORE, LEN_SHORT, 1'b0, ZW, ZW, ZW, ret);
    tick();
    compare(wbDataQ, 16'h7777);
  endtask

  task automatic t_traps;
    logic [15:0] ret;
    logic [4:0] ops [4] = '{5'h1e, 5'h1f, OP_TRAP, OP_MOVE};
    logic [2:0] lens [4] = '{LEN_SHORT, LEN_SHORT, LEN_LONG, 3'h3};
    ret = pcM + 16'h0002;
    @(posedge clk_sys);
    trapNum <= 7'h05;
    run(OP_TRAP, LEN_SHORT, 1'b0, ZW, ZW, ZW, 16'h0014);
    compare(segQ, TRAP_SEG);
    run(OP_RETURN_INT, LEN_SHORT, 1'b0, ZW, ZW, ZW, ret);
    tick();
    compare(segQ, 8'h03);
    for (int i = 0; i < 4; i++) begin
      run(ops[i], lens[i], 1'b0, ZW, ZW, ZW, {7'h00, ILLEGAL_TRAP_NUM, 2'b00});
      compare(illegalTrapQ, 1'b1);
      tick();
      compare(illegalTrapQ, 1'b0);
    end
  endtask

  task automatic t_addr;
    run(OP_END_INIT, LEN_LONG, 1'b0, ZW, ZW, ZW, pcM + 16'h0004);
    compare(rstOutPinNQ, 1'b1);
    run(OP_MOVE, LEN_LONG, 1'b0, ZW, ZW, ZW, pcM + 16'h0004);
    compare(dataAddrQ, {10'h2a5, 14'h0321});
    @(posedge clk_sys);
    sfrShortMode <= 1'b1;
    sfrShortAddr <= 8'h50;
    run(OP_MOVE, LEN_LONG, 1'b0, ZW, ZW, ZW, pcM + 16'h0004);
    compare(dataAddrQ, SFR_BASE + 24'h0000a0);
    @(posedge clk_sys);
    sfrShortMode <= 1'b0;
    prefixValue <= 10'h0c3;
    run(OP_EXT_SEG, LEN_SHORT, 1'b0, ZW, ZW, ZW, pcM + 16'h0002);
    compare(extActiveQ, 1'b1);
    run(OP_MOVE, LEN_LONG, 1'b0, ZW, ZW, ZW, pcM + 16'h0004);
    compare(dataAddrQ, {8'hc3, 16'h4321});
    compare(extActiveQ, 1'b0);
    @(posedge clk_sys);
    prefixValue <= 10'h155;
    prefixSpan <= 2'h1;
    instExtReg <= 1'b1;
    sfrShortMode <= 1'b1;
    sfrShortAddr <= 8'h1b;
    run(OP_EXT_PAGE, LEN_LONG, 1'b0, ZW, ZW, ZW, pcM + 16'h0004);
    run(OP_MOVE, LEN_SHORT, 1'b0, ZW, ZW, ZW, pcM + 16'h0002);
    compare(dataAddrQ, ESFR_BASE + 24'h000036);
    @(posedge clk_sys);
    sfrShortMode <= 1'b0;
    run(OP_MOVE, LEN_SHORT, 1'b0, ZW, ZW, ZW, pcM + 16'h0002);
    compare(dataAddrQ, {10'h155, 14'h0321});
    compare(extActiveQ, 1'b0);
  endtask

  task automatic t_sleep;
    run(OP_IDLE, LEN_LONG, 1'b0, ZW, ZW, ZW, pcM + 16'h0004);
    repeat (3) tick();
    compare(idleQ, 1'b1);
    compare(instReady, 1'b0);
    @(posedge clk_sys);
    wakeReq <= 1'b1;
    @(posedge clk_sys);
    wakeReq <= 1'b0;
    tick();
    compare(idleQ, 1'b0);
    compare(instReady, 1'b1);
    do_reset();
    run(OP_POWER_DOWN, LEN_LONG, 1'b0, ZW, ZW, ZW, pcM + 16'h0004);
    compare(powerDownQ, 1'b0);
    @(posedge clk_sys);
    nmiPinN <= 1'b0;
    repeat (3) tick();
    run(OP_POWER_DOWN, LEN_LONG, 1'b0, ZW, ZW, ZW, pcM + 16'h0004);
    repeat (4) tick();
    compare(powerDownQ, 1'b1);
    compare(instReady, 1'b0);
  endtask

  initial begin
    do_reset();
    t_moves();
    t_jumps();
    t_bits();
    t_inter_segment_call();
    t_stack();
    t_traps();
    t_addr();
    t_sleep();
    results();
  end
endmodule
